// *** pkg/mbs_pkg.sv ***
// constants for the monitor block status builder (bits 15..0)
// assumes one 200 MHz clock and a plain register port
package mbs_pkg;
	// block status word bit positions
	localparam int BIT_CW_CONTENT = 0;
	localparam int BIT_CW2_ERR    = 1;
	localparam int BIT_RRGSA      = 2;
	localparam int BIT_WORD_ERR   = 3;
	localparam int BIT_SYNC_ERR   = 4;
	localparam int BIT_LEN_ERR    = 5;
	localparam int BIT_STAT_SET   = 6;
	localparam int BIT_ROLLOVER   = 7;
	localparam int BIT_GOOD       = 8;
	localparam int BIT_TIMEOUT    = 9;
	localparam int BIT_GAP        = 10;
	localparam int BIT_RTRT       = 11;
	localparam int BIT_ERR_SUM    = 12;
	localparam int BIT_BUS        = 13;
	localparam int BIT_BEGIN      = 14;
	localparam int BIT_END        = 15;
	// command word fields
	localparam int CW_RTA_HI = 15;
	localparam int CW_RTA_LO = 11;
	localparam int CW_TR     = 10;
	localparam int CW_SA_HI  = 9;
	localparam int CW_SA_LO  = 5;
	localparam int CW_MC_MSB = 4;
	localparam logic [4:0] SA_MODE_LO = 5'h00;
	localparam logic [4:0] SA_MODE_HI = 5'h1F;
	// register indexes
	localparam logic [3:0] REG_CONFIG   = 4'h0;
	localparam logic [3:0] REG_LIVE     = 4'h1;
	localparam logic [3:0] REG_IRQ_STAT = 4'h2;
	localparam logic [3:0] REG_IRQ_MASK = 4'h3;
	localparam logic [3:0] REG_LAST     = 4'h4;
	localparam int CFG_TMO_HI = 15;
	localparam int CFG_TMO_LO = 14;
	localparam logic [15:0] CONFIG_RST   = 16'h0000;
	localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR  = 1;
	localparam int IRQ_TMO  = 2;
	// timing
	localparam int CLK_MHZ      = 200;
	localparam int US_CYC       = CLK_MHZ;
	localparam int BEGIN_DLY_NS  = 3500;
	localparam int BEGIN_DLY_CYC = (BEGIN_DLY_NS * CLK_MHZ) / 1000;
	localparam int TMO_US_SEL0  = 15;
	localparam int TMO_US_SEL1  = 20;
	localparam int TMO_US_SEL2  = 50;
	localparam int TMO_US_SEL3  = 130;
endpackage

// *** rtl/mbs_resp_timer.sv ***
// response timeout timer counting whole microseconds
// assumes start and stop are one-cycle pulses from same-clock logic
`timescale 1ns/1ps
module mbs_resp_timer
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	// control
	input  wire logic       start_i,
	input  wire logic       stop_i,
	input  wire logic [1:0] sel_i,
	// result
	output logic            expire_o
);
	logic [7:0] div_r;
	logic [7:0] us_r;
	logic [7:0] lim;
	logic       run_r;
	logic       tick;

	always_comb
	begin
		unique case (sel_i)
			2'h0: lim = 8'(mbs_pkg::TMO_US_SEL0);
			2'h1: lim = 8'(mbs_pkg::TMO_US_SEL1);
			2'h2: lim = 8'(mbs_pkg::TMO_US_SEL2);
			2'h3: lim = 8'(mbs_pkg::TMO_US_SEL3);
		endcase
	end

	// divider restarts on start so the first tick is a full microsecond
	assign tick = run_r && (div_r == 8'(mbs_pkg::US_CYC - 1));

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || start_i || tick)
			div_r <= 8'h00;
		else if (run_r)
			div_r <= div_r + 8'h01;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			run_r    <= 1'b0;
			us_r     <= 8'h00;
			expire_o <= 1'b0;
		end
		else
		begin
			expire_o <= 1'b0;
			if (start_i)
			begin
				run_r <= 1'b1;
				us_r  <= 8'h00;
			end
			else if (stop_i)
				run_r <= 1'b0;
			else if (tick)
			begin
				us_r <= us_r + 8'h01;
				if (us_r + 8'h01 == lim)
				begin
					run_r    <= 1'b0;
					expire_o <= 1'b1;
				end
			end
		end
	end
endmodule

// *** rtl/mbs_status_builder.sv ***
// builds the per-message block status word and writes it to the buffer
// assumes decoder events are same-clock pulses, one message at a time
`timescale 1ns/1ps
module mbs_status_builder
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	// register port
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [15:0]      reg_rdata_o,
	output logic             irq_o,
	// command words from the decoder
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd2_valid_i,
	input  wire logic [15:0] cmd_word_i,
	input  wire logic        cmd2_sync_err_i,
	input  wire logic        bus_b_i,
	input  wire logic        filter_pass_i,
	// status response
	input  wire logic        resp_wait_i,
	input  wire logic        status_rx_i,
	input  wire logic        status_busy_i,
	input  wire logic        msg_end_i,
	// lower error events
	input  wire logic        cw_content_err_i,
	input  wire logic        rrgsa_err_i,
	input  wire logic        word_err_i,
	input  wire logic        sync_err_i,
	input  wire logic        length_err_i,
	input  wire logic        status_set_i,
	input  wire logic        rollover_i,
	input  wire logic        gap_err_i,
	// buffer write
	output logic             word_wr_o,
	output logic [15:0]      block_status_word_o,
	output logic             message_begin_flag_o
);
	////////////////////////////////////////////////////////////////////
	// message state

	logic        active_r;
	logic        tx_r;
	logic        busy_r;
	logic [4:0]  rta1_r;
	logic        bus_select_flag_r;
	logic        terminal_to_terminal_flag_r;
	logic        illegal_gap_flag_r;
	logic        timeout_flag_r;
	logic        error_summary_flag_r;
	logic [7:0]  low_r;
	logic [9:0]  beg_cnt_r;
	logic        beg_run_r;
	logic [15:0] config_r;
	logic [2:0]  irq_stat_r;
	logic [2:0]  irq_mask_r;
	logic [15:0] last_r;
	logic        tmo_exp;
	logic        cmd_start;
	logic        supersede;
	logic        finish;
	logic        rx_mode_undef;
	logic        cw2_hard;
	logic        cw2_soft;
	logic        len_ok;
	logic [7:0]  low_set;
	logic        sum_set;
	logic [15:0] final_word;

	// a second command never opens a message by itself
	assign cmd_start = cmd_valid_i && !cmd2_valid_i;
	// an end in the same cycle closes cleanly, so no cut is counted
	assign supersede = cmd_start && active_r && !msg_end_i;
	assign finish    = (active_r && msg_end_i) || supersede;

	////////////////////////////////////////////////////////////////////
	// error decode

	// undefined receive mode code: T/R low, mode subaddress, code 0..15
	assign rx_mode_undef = cmd_start && !cmd_word_i[mbs_pkg::CW_TR]
		&& (cmd_word_i[mbs_pkg::CW_SA_HI:mbs_pkg::CW_SA_LO] == mbs_pkg::SA_MODE_LO
		|| cmd_word_i[mbs_pkg::CW_SA_HI:mbs_pkg::CW_SA_LO] == mbs_pkg::SA_MODE_HI)
		&& !cmd_word_i[mbs_pkg::CW_MC_MSB];

	// a receive second command or a bad sync is a real fault
	assign cw2_hard = cmd2_valid_i && (!cmd_word_i[mbs_pkg::CW_TR] || cmd2_sync_err_i);
	assign cw2_soft = cmd2_valid_i
		&& (cmd_word_i[mbs_pkg::CW_SA_HI:mbs_pkg::CW_SA_LO] == mbs_pkg::SA_MODE_LO
		|| cmd_word_i[mbs_pkg::CW_SA_HI:mbs_pkg::CW_SA_LO] == mbs_pkg::SA_MODE_HI
		|| cmd_word_i[mbs_pkg::CW_RTA_HI:mbs_pkg::CW_RTA_LO] == rta1_r);

	// busy or a transmit timeout never counts as a length error
	assign len_ok = length_err_i && !busy_r && !status_busy_i
		&& !(tx_r && (timeout_flag_r || tmo_exp));

	always_comb
	begin
		low_set = 8'h00;
		// a superseding command's own mode code belongs to the next word
		low_set[mbs_pkg::BIT_CW_CONTENT] = cw_content_err_i;
		low_set[mbs_pkg::BIT_CW2_ERR]    = cw2_hard || cw2_soft;
		low_set[mbs_pkg::BIT_RRGSA]      = rrgsa_err_i;
		low_set[mbs_pkg::BIT_WORD_ERR]   = word_err_i;
		low_set[mbs_pkg::BIT_SYNC_ERR]   = sync_err_i;
		low_set[mbs_pkg::BIT_LEN_ERR]    = len_ok;
		low_set[mbs_pkg::BIT_STAT_SET]   = status_set_i;
		low_set[mbs_pkg::BIT_ROLLOVER]   = rollover_i;
	end

	// mode-code and same-address second commands stay out of the summary
	assign sum_set = gap_err_i || tmo_exp || len_ok || sync_err_i || word_err_i
		|| rrgsa_err_i
		|| cw2_hard
		|| cw_content_err_i
		|| supersede;

	////////////////////////////////////////////////////////////////////
	// response timer

	// a close with no response wait in the same cycle stops the timer, so a stale expiry cannot hit the next message
	mbs_resp_timer u_timer
	(
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.start_i   (resp_wait_i && active_r),
		.stop_i    (status_rx_i || finish),
		.sel_i     (config_r[mbs_pkg::CFG_TMO_HI:mbs_pkg::CFG_TMO_LO]),
		.expire_o  (tmo_exp)
	);

	////////////////////////////////////////////////////////////////////
	// flag accumulation

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			active_r <= 1'b0;
			tx_r     <= 1'b0;
			rta1_r   <= 5'h00;
			busy_r   <= 1'b0;
		end
		else
		begin
			if (cmd_start)
			begin
				active_r <= 1'b1;
				tx_r     <= cmd_word_i[mbs_pkg::CW_TR];
				rta1_r   <= cmd_word_i[mbs_pkg::CW_RTA_HI:mbs_pkg::CW_RTA_LO];
				busy_r   <= 1'b0;
			end
			else
			begin
				if (finish)
					active_r <= 1'b0;
				if (cmd2_valid_i)
					tx_r <= 1'b1;
				if (status_rx_i && status_busy_i)
					busy_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			bus_select_flag_r <= 1'b0;
		else if (cmd_start)
			bus_select_flag_r <= bus_b_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || cmd_start)
			terminal_to_terminal_flag_r <= 1'b0;
		else if (cmd2_valid_i && active_r)
			terminal_to_terminal_flag_r <= 1'b1;
	end

	// error bits restart with each new command
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			low_r                <= 8'h00;
			illegal_gap_flag_r   <= 1'b0;
			timeout_flag_r       <= 1'b0;
			error_summary_flag_r <= 1'b0;
		end
		else if (cmd_start)
		begin
			low_r <= 8'h00;
			low_r[mbs_pkg::BIT_CW_CONTENT] <= rx_mode_undef;
			illegal_gap_flag_r   <= 1'b0;
			timeout_flag_r       <= 1'b0;
			error_summary_flag_r <= 1'b0;
		end
		else if (active_r)
		begin
			low_r <= low_r | low_set;
			if (gap_err_i)
				illegal_gap_flag_r <= 1'b1;
			if (tmo_exp)
				timeout_flag_r <= 1'b1;
			if (sum_set)
				error_summary_flag_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// start-of-message delay

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			beg_run_r <= 1'b0;
			beg_cnt_r <= 10'h000;
			message_begin_flag_o <= 1'b0;
		end
		else if (cmd_start)
		begin
			// unfiltered messages never start the count, so the flag stays low
			beg_run_r <= filter_pass_i;
			beg_cnt_r <= 10'h000;
			message_begin_flag_o <= 1'b0;
		end
		else if (finish)
		begin
			beg_run_r <= 1'b0;
			message_begin_flag_o <= 1'b0;
		end
		else if (beg_run_r)
		begin
			beg_cnt_r <= beg_cnt_r + 10'h001;
			// compare two short: start edge and flag register supply the rest
			if (beg_cnt_r == 10'(mbs_pkg::BEGIN_DLY_CYC - 2))
			begin
				beg_run_r <= 1'b0;
				message_begin_flag_o <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// final word, taken from this cycle's events as well as the stored flags

	always_comb
	begin
		final_word = 16'h0000;
		final_word[7:0] = low_r | low_set;
		final_word[mbs_pkg::BIT_GAP]     = illegal_gap_flag_r || gap_err_i;
		final_word[mbs_pkg::BIT_TIMEOUT] = timeout_flag_r || tmo_exp;
		final_word[mbs_pkg::BIT_RTRT]    = terminal_to_terminal_flag_r;
		final_word[mbs_pkg::BIT_ERR_SUM] = error_summary_flag_r || sum_set;
		final_word[mbs_pkg::BIT_GOOD]    = !(error_summary_flag_r || sum_set);
		final_word[mbs_pkg::BIT_BUS]     = bus_select_flag_r;
		final_word[mbs_pkg::BIT_BEGIN]   = 1'b0;
		final_word[mbs_pkg::BIT_END]     = 1'b1;
	end

	// word goes out one cycle after the finish so nothing is half-evaluated
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			word_wr_o           <= 1'b0;
			block_status_word_o <= 16'h0000;
		end
		else
		begin
			word_wr_o <= finish;
			if (finish)
				block_status_word_o <= final_word;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			last_r <= 16'h0000;
		else if (finish)
			last_r <= final_word;
	end

	////////////////////////////////////////////////////////////////////
	// registers and interrupt

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			config_r   <= mbs_pkg::CONFIG_RST;
			irq_mask_r <= mbs_pkg::IRQ_MASK_RST;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == mbs_pkg::REG_CONFIG)
				config_r <= reg_wdata_i;
			if (reg_addr_i == mbs_pkg::REG_IRQ_MASK)
				irq_mask_r <= reg_wdata_i[2:0];
		end
	end

	// a new event in the read cycle survives the read-clear
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			irq_stat_r <= 3'h0;
		else
		begin
			irq_stat_r <= ((reg_rd_i && reg_addr_i == mbs_pkg::REG_IRQ_STAT)
				? 3'h0 : irq_stat_r)
				| {tmo_exp, finish && final_word[mbs_pkg::BIT_ERR_SUM], finish};
		end
	end

	// level output: stays up until the status read clears it
	assign irq_o = |(irq_stat_r & irq_mask_r);

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				mbs_pkg::REG_CONFIG:   reg_rdata_o <= config_r;
				mbs_pkg::REG_LIVE:     reg_rdata_o <= {1'b0, message_begin_flag_o,
					bus_select_flag_r, error_summary_flag_r,
					terminal_to_terminal_flag_r, illegal_gap_flag_r,
					timeout_flag_r, 1'b0, low_r};
				mbs_pkg::REG_IRQ_STAT: reg_rdata_o <= {13'h0000, irq_stat_r};
				mbs_pkg::REG_IRQ_MASK: reg_rdata_o <= {13'h0000, irq_mask_r};
				mbs_pkg::REG_LAST:     reg_rdata_o <= last_r;
				default:               reg_rdata_o <= 16'h0000;
			endcase
		end
		else
			reg_rdata_o <= 16'h0000;
	end
endmodule

// *** tb/mbs_bus_model.sv ***
// far-side model: decoder events of the monitored bus, one pulse per pulse call, two or three per msg call
// assumes callers sit in the bench and share sys_clk_i
`timescale 1ns/1ps
module mbs_bus_model
(
	// clock
	input  wire logic        sys_clk_i,
	// event pulses and command word
	output logic [16:0]      ev_o,
	output logic [15:0]      word_o
);
	logic [16:0] ev_r = 17'h00000;
	logic [15:0] word_r = 16'h0000;
	assign ev_o   = ev_r;
	assign word_o = word_r;
	////////////////////////////////////////////////////////////////
	// idle word is inverted so a stale value never looks valid
	task automatic pulse(input logic [16:0] ev, input logic [15:0] w);
		@(posedge sys_clk_i);
		ev_r   <= ev;
		word_r <= w;
		@(posedge sys_clk_i);
		ev_r   <= 17'h00000;
		word_r <= ~w;
	endtask
	// gap sets how slowly the far side answers
	task automatic msg(input logic [15:0] w, w2, input logic [16:0] hd, md, bd, input int gap);
		pulse(hd, w);
		if (md != 17'h00000)
			pulse(md, w2);
		repeat (gap) @(posedge sys_clk_i);
		pulse(bd | 17'h00100, w);
	endtask
endmodule

// *** tb/mbs_status_props.sv ***
// checker for the block status builder, top module ports only
// assumes one clock domain; bound into every builder instance
`timescale 1ns/1ps
module mbs_status_props
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	// watched ports
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd2_valid_i,
	input  wire logic        bus_b_i,
	input  wire logic        filter_pass_i,
	input  wire logic        msg_end_i,
	input  wire logic        word_wr_o,
	input  wire logic [15:0] block_status_word_o,
	input  wire logic        message_begin_flag_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	wire logic [15:0] w = block_status_word_o;
	logic             bus_q_r;
	always_ff @(posedge sys_clk_i)
	begin
		if (cmd_valid_i && !cmd2_valid_i)
			bus_q_r <= bus_b_i;
	end
	sequence s_msg_close;
		msg_end_i ##1 word_wr_o;
	endsequence
	////////////////////////////////////////////////////////////////
	end_word_a: assert property (s_msg_close |-> w[15] && !w[14])
		else $error("end word flags wrong");
	begin_drop_a: assert property (s_msg_close |-> !message_begin_flag_o)
		else $error("begin flag kept after end");
	good_flag_a: assert property (word_wr_o |-> w[8] == !w[12])
		else $error("good flag disagrees with summary");
	err_sum_a: assert property (word_wr_o && (|{w[10:9], w[5:2]}) |-> w[12])
		else $error("summary missing for error bit");
	rtrt_tag_a: assert property (word_wr_o && w[1] |-> w[11])
		else $error("second command error without transfer flag");
	bus_sel_a: assert property (s_msg_close |-> w[13] == bus_q_r)
		else $error("bus flag wrong");
	begin_delay_a: assert property ($rose(message_begin_flag_o) |->
		$past(cmd_valid_i && filter_pass_i, 700))
		else $error("begin flag at wrong time");
	write_cause_a: assert property (word_wr_o |-> $past(msg_end_i) || $past(cmd_valid_i))
		else $error("status write without cause");
endmodule
bind mbs_status_builder mbs_status_props u_props
(
	.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
	.cmd2_valid_i(cmd2_valid_i), .bus_b_i(bus_b_i), .filter_pass_i(filter_pass_i),
	.msg_end_i(msg_end_i), .word_wr_o(word_wr_o), .block_status_word_o(block_status_word_o),
	.message_begin_flag_o(message_begin_flag_o)
);

// *** tb/tb.sv ***
// bench for the block status builder: register port and message scenarios
// assumes the bus model drives every decoder event
`timescale 1ns/1ps
module tb;
	localparam logic [16:0] CMD = 17'h00001, C2 = 17'h00002, C2S = 17'h00004;
	localparam logic [16:0] BB = 17'h00008, FLT = 17'h00010, RW = 17'h00020;
	localparam logic [16:0] STS = 17'h00040, BSY = 17'h00080, END = 17'h00100;
	localparam logic [16:0] LEN = 17'h02000, NONE = 17'h00000;
	logic        sys_clk;
	logic        srst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	wire  logic [15:0] rdata, stat_w, cw;
	wire  logic [16:0] ev;
	wire  logic        irq, stat_wr, begin_f;
	int          mismatches = 0;
	int          compares = 0;
	logic [15:0] ev_e [8] = '{16'h9001, 16'h9004, 16'h9008, 16'h9010,
		16'h9020, 16'h8140, 16'h8180, 16'h9400};
	logic [15:0] rt_w [4] = '{16'h2C22, 16'h3402, 16'h3022, 16'h3422};
	logic [16:0] rt_h [4] = '{C2, C2, C2, C2 | C2S};
	logic [15:0] rt_e [4] = '{16'h8902, 16'h8902, 16'h9802, 16'h9802};
	mbs_status_builder dut
	(
		.sys_clk_i(sys_clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
		.cmd_valid_i(ev[0]), .cmd2_valid_i(ev[1]), .cmd_word_i(cw), .cmd2_sync_err_i(ev[2]),
		.bus_b_i(ev[3]), .filter_pass_i(ev[4]), .resp_wait_i(ev[5]), .status_rx_i(ev[6]),
		.status_busy_i(ev[7]), .msg_end_i(ev[8]), .cw_content_err_i(ev[9]),
		.rrgsa_err_i(ev[10]), .word_err_i(ev[11]), .sync_err_i(ev[12]),
		.length_err_i(ev[13]), .status_set_i(ev[14]), .rollover_i(ev[15]),
		.gap_err_i(ev[16]), .word_wr_o(stat_wr), .block_status_word_o(stat_w),
		.message_begin_flag_o(begin_f)
	);
	mbs_bus_model bm (.sys_clk_i(sys_clk), .ev_o(ev), .word_o(cw));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// word counts only in the write cycle
	function automatic logic [15:0] seen_w();
		return (stat_wr === 1'b1) ? stat_w : 16'h0000;
	endfunction
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd   <= 1'b0;
		#1;
		chk(rdata, exp, what);
	endtask
	task automatic run(input logic [15:0] w, w2, input logic [16:0] md, bd, input int gap,
		input logic [15:0] exp);
		bm.msg(w, w2, CMD, md, bd, gap);
		#1;
		chk(seen_w(), exp, "status word");
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#400000;
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		rd_chk(mbs_pkg::REG_CONFIG, mbs_pkg::CONFIG_RST, "config reset");
		rd_chk(mbs_pkg::REG_IRQ_MASK, 16'h0000, "mask reset");
		wr_reg(4'hF, 16'hFFFF);
		rd_chk(4'hF, 16'h0000, "unmapped");
		$display("test registers done");
		bm.pulse(CMD | BB | FLT, 16'h0822);
		repeat (690) @(posedge sys_clk);
		#1 chk({15'h0000, begin_f}, 16'h0000, "begin early");
		repeat (20) @(posedge sys_clk);
		#1 chk({15'h0000, begin_f}, 16'h0001, "begin set");
		rd_chk(mbs_pkg::REG_LIVE, 16'h6000, "live flags");
		bm.pulse(END, 16'h0822);
		#1 chk(seen_w(), 16'hA100, "bus b word");
		chk({15'h0000, begin_f}, 16'h0000, "begin cleared");
		chk({15'h0000, irq}, 16'h0000, "irq masked");
		wr_reg(mbs_pkg::REG_IRQ_MASK, 16'h0007);
		chk({15'h0000, irq}, 16'h0001, "irq raised");
		rd_chk(mbs_pkg::REG_IRQ_STAT, 16'h0001, "irq status");
		chk({15'h0000, irq}, 16'h0000, "irq cleared");
		bm.pulse(CMD, 16'h1022);
		repeat (720) @(posedge sys_clk);
		#1 chk({15'h0000, begin_f}, 16'h0000, "filtered out");
		bm.pulse(END, 16'h1022);
		$display("test begin flag and irq done");
		for (int i = 0; i < 8; i++)
			run(16'h0822, 16'h0000, RW, STS | (17'h00200 << i), 2, ev_e[i]);
		for (int i = 0; i < 4; i++)
			run(16'h2822, rt_w[i], rt_h[i], STS, 2, rt_e[i]);
		run(16'h1803, 16'h0000, RW, STS, 2, 16'h8101);
		run(16'h1BEF, 16'h0000, RW, STS, 2, 16'h8101);
		run(16'h0C22, 16'h0000, RW, STS | BSY | LEN, 2, 16'h8100);
		$display("test error bits done");
		bm.pulse(CMD, 16'h0822);
		bm.pulse(CMD, 16'h1022);
		#1 chk(seen_w() & 16'h1100, 16'h1000, "superseded");
		bm.pulse(END, 16'h1022);
		#1 chk(seen_w(), 16'h8100, "after supersede");
		$display("test supersede done");
		rd_chk(mbs_pkg::REG_IRQ_STAT, 16'h0003, "irq errors");
		wr_reg(mbs_pkg::REG_CONFIG, 16'h4000);
		run(16'h0C22, 16'h0000, RW, STS, 3900, 16'h8100);
		run(16'h0C22, 16'h0000, RW, NONE, 4100, 16'h9200);
		rd_chk(mbs_pkg::REG_IRQ_STAT, 16'h0007, "irq timeout");
		wr_reg(mbs_pkg::REG_CONFIG, 16'h8000);
		run(16'h0C22, 16'h0000, RW, NONE, 10100, 16'h9200);
		wr_reg(mbs_pkg::REG_CONFIG, 16'hC000);
		run(16'h0C22, 16'h0000, RW, STS, 25900, 16'h8100);
		rd_chk(mbs_pkg::REG_LAST, 16'h8100, "last word");
		$display("test timeout done");
		tally_and_finish();
	end
endmodule
